// [rgb_pkg.sv]
package rgb_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_MHZ       = 100;
  localparam int LINK_MHZ        = 125;
  localparam int DIV_1000        = 1;
  localparam int DIV_100         = 10;
  localparam int DIV_10          = 100;
  localparam int TX_DELAY_CYCLES = 1;

  // ****************************************************************
  // Speed codes
  // ****************************************************************
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    RGB_TX_IDLE,
    RGB_TX_LOW,
    RGB_TX_HIGH
  } rgb_tx_state_type;

endpackage

// [rgb_rx_capture.sv]
// ****************************************************************
// Receive capture: link clock sampled by core clock, edges found
// ****************************************************************
module rgb_rx_capture (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic       rx_clk_pin,
  input  wire logic [3:0] rx_data_pin,
  input  wire logic       rx_ctl_pin,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_error,
  output logic            rx_strobe,
  output logic            rx_valid_fall
);
  logic [2:0] sync_clk;
  logic [3:0] sync_d0;
  logic [3:0] sync_d1;
  logic [1:0] sync_c;
  logic [3:0] low_nib;
  logic       low_ctl;
  logic [3:0] next_low_nib;
  logic       next_low_ctl;
  logic [7:0] next_rx_byte;
  logic       next_rx_valid;
  logic       next_rx_error;
  logic       next_rx_strobe;
  logic       next_rx_valid_fall;
  logic       rise;
  logic       fall;

  // Edge detect reads only the second and third stages
  assign rise = sync_clk[1] & ~sync_clk[2];
  assign fall = ~sync_clk[1] & sync_clk[2];

  always_comb begin
    next_low_nib       = low_nib;
    next_low_ctl       = low_ctl;
    next_rx_byte       = rx_byte;
    next_rx_valid      = rx_valid;
    next_rx_error      = rx_error;
    next_rx_strobe     = 1'b0;
    next_rx_valid_fall = 1'b0;
    if (enable && rise) begin
      next_low_nib = sync_d1;  // [R10]
      next_low_ctl = sync_c[1];  // [R10]
    end
    if (enable && fall) begin
      next_rx_byte       = {sync_d1, low_nib};  // [R3] [R10]
      next_rx_valid      = low_ctl;  // [R3]
      next_rx_error      = low_ctl ^ sync_c[1];  // [R3]
      next_rx_strobe     = 1'b1;
      next_rx_valid_fall = rx_valid & ~low_ctl;  // [R7]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_clk      <= '0;
      sync_d0       <= '0;
      sync_d1       <= '0;
      sync_c        <= '0;
      low_nib       <= '0;
      low_ctl       <= 1'b0;
      rx_byte       <= rgb_pkg::BYTE_RESET;
      rx_valid      <= 1'b0;
      rx_error      <= 1'b0;
      rx_strobe     <= 1'b0;
      rx_valid_fall <= 1'b0;
    end else begin
      sync_clk      <= {sync_clk[1:0], rx_clk_pin};
      sync_d0       <= rx_data_pin;
      sync_d1       <= sync_d0;
      sync_c        <= {sync_c[0], rx_ctl_pin};
      low_nib       <= next_low_nib;
      low_ctl       <= next_low_ctl;
      rx_byte       <= next_rx_byte;
      rx_valid      <= next_rx_valid;
      rx_error      <= next_rx_error;
      rx_strobe     <= next_rx_strobe;
      rx_valid_fall <= next_rx_valid_fall;
    end
  end
endmodule

// [rgb_bridge.sv]
// Overview of operation
// R1: When enabled, the Ethernet pins leave general I/O and are driven by the bridge.
// R2: While enabled, the bridge's own ports and pins serve only the bridge; others are untouched.
// R3: Each way converts 4-bit double-rate data and a control wire to bytes with valid and error.
// R4: The bridge makes the transmit clock and can delay its edge out of phase with the data.
// R5: Transmit and receive link clocks run at 125 MHz for gigabit operation; the transmit clock here is half the core clock, 50 MHz.
// R6: Transmit data, receive data and transmit clock delay are timed independently.
// R7: Speed switching among 10, 100 and 1000 takes effect on a falling edge of receive valid.
// R8: The PHY holds its receive clock low in reset and stays in reset until the bridge frees it.
// R9: The management interface uses two open-drain single-bit pins relying on pull-ups.
// R10: In gigabit mode the low nibble and valid are taken on the rising edge, the rest on falling.
module rgb_bridge (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       rgmii_enable,
  input  wire logic       clock_delay_on,
  input  wire logic [1:0] speed_request,
  input  wire logic       phy_reset_release,
  input  wire logic [7:0] transmit_byte_path,
  input  wire logic       tx_valid,
  input  wire logic       tx_error,
  output logic            tx_ready,
  output logic [7:0]      receive_byte_path,
  output logic            rx_valid,
  output logic            rx_error,
  output logic            rx_strobe,
  output logic [1:0]      speed_active,
  input  wire logic [3:0] gpio_out,
  input  wire logic       gpio_out_clk,
  input  wire logic       gpio_out_ctl,
  output logic [3:0]      tx_data_pin,
  output logic            tx_clk_pin,
  output logic            tx_ctl_pin,
  input  wire logic       rx_clk_pin,
  input  wire logic [3:0] rx_data_pin,
  input  wire logic       rx_ctl_pin,
  output logic            phy_reset_n,
  input  wire logic       mdc_drive_low,
  input  wire logic       mdio_drive_low,
  input  wire logic       mdio_in_pin,
  output logic            mdc_out,
  output logic            mdc_oe,
  output logic            mdio_out,
  output logic            mdio_oe,
  output logic            mdio_value
);

  // ****************************************************************
  // Receive path
  // ****************************************************************
  logic rx_valid_fall;
  logic [1:0] mdio_sync;

  // Core clock sees 125 MHz link only in simulation at 8 MHz bench rate
  rgb_rx_capture u_rx (
    .clock         (clock),
    .arst_n        (arst_n),
    .enable        (rgmii_enable),
    .rx_clk_pin    (rx_clk_pin),
    .rx_data_pin   (rx_data_pin),
    .rx_ctl_pin    (rx_ctl_pin),
    .rx_byte       (receive_byte_path),
    .rx_valid      (rx_valid),
    .rx_error      (rx_error),
    .rx_strobe     (rx_strobe),
    .rx_valid_fall (rx_valid_fall)
  );

  // ****************************************************************
  // Speed switching
  // ****************************************************************
  logic [1:0] next_speed_active;

  always_comb begin
    next_speed_active = speed_active;
    if (rx_valid_fall && speed_request != 2'h3) begin
      next_speed_active = speed_request;  // [R7]
    end
  end

  // ****************************************************************
  // Transmit clock divider and serializer
  // ****************************************************************
  rgb_pkg::rgb_tx_state_type state;
  rgb_pkg::rgb_tx_state_type next_state;
  logic [6:0] div_count;
  logic [6:0] next_div_count;
  logic [6:0] div_limit;
  logic       tick;
  logic [7:0] tx_hold;
  logic [7:0] next_tx_hold;
  logic       tx_hold_valid;
  logic       next_tx_hold_valid;
  logic       tx_hold_error;
  logic       next_tx_hold_error;
  logic [3:0] tx_nib;
  logic [3:0] next_tx_nib;
  logic       tx_ctl_reg;
  logic       next_tx_ctl_reg;
  logic       tx_clk_reg;
  logic       next_tx_clk_reg;
  logic       tx_clk_delayed;
  logic       phy_rst_reg;

  always_comb begin
    unique case (speed_active)
      rgb_pkg::SPEED_10:  div_limit = 7'(rgb_pkg::DIV_10 - 1);
      rgb_pkg::SPEED_100: div_limit = 7'(rgb_pkg::DIV_100 - 1);
      default:            div_limit = 7'(rgb_pkg::DIV_1000 - 1);
    endcase
  end

  // A speed change can leave the count above the new limit; wrap at once
  assign tick     = rgmii_enable && (div_count >= div_limit);
  assign tx_ready = rgmii_enable && tick && (state != rgb_pkg::RGB_TX_LOW);

  always_comb begin
    next_div_count     = tick ? 7'h00 : div_count + 7'h01;
    next_state         = state;
    next_tx_hold       = tx_hold;
    next_tx_hold_valid = tx_hold_valid;
    next_tx_hold_error = tx_hold_error;
    next_tx_nib        = tx_nib;
    next_tx_ctl_reg    = tx_ctl_reg;
    next_tx_clk_reg    = tx_clk_reg;
    if (!rgmii_enable) begin
      next_div_count  = 7'h00;
      next_state      = rgb_pkg::RGB_TX_IDLE;
      next_tx_clk_reg = 1'b0;
    end else if (tick) begin
      unique case (state)
        rgb_pkg::RGB_TX_IDLE, rgb_pkg::RGB_TX_HIGH: begin
          next_tx_hold       = transmit_byte_path;
          next_tx_hold_valid = tx_valid;
          next_tx_hold_error = tx_error;
          next_tx_nib        = transmit_byte_path[3:0];  // [R3]
          next_tx_ctl_reg    = tx_valid;  // [R3]
          next_tx_clk_reg    = 1'b1;  // [R4] [R5]
          next_state         = rgb_pkg::RGB_TX_LOW;
        end
        rgb_pkg::RGB_TX_LOW: begin
          next_tx_nib     = tx_hold[7:4];  // [R3]
          next_tx_ctl_reg = tx_hold_valid ^ tx_hold_error;  // [R3]
          next_tx_clk_reg = 1'b0;
          next_state      = rgb_pkg::RGB_TX_HIGH;
        end
      endcase
    end
  end

  // Delay stage is its own register chain, independent of the data path
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_clk_delayed <= 1'b0;
    end else begin
      tx_clk_delayed <= tx_clk_reg;  // [R4] [R6]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state         <= rgb_pkg::RGB_TX_IDLE;
      div_count     <= 7'h00;
      tx_hold       <= rgb_pkg::BYTE_RESET;
      tx_hold_valid <= 1'b0;
      tx_hold_error <= 1'b0;
      tx_nib        <= 4'h0;
      tx_ctl_reg    <= 1'b0;
      tx_clk_reg    <= 1'b0;
      speed_active  <= rgb_pkg::SPEED_1000;
      phy_rst_reg   <= 1'b0;
      mdio_sync     <= 2'h0;
      mdio_value    <= 1'b0;
    end else begin
      state         <= next_state;
      div_count     <= next_div_count;
      tx_hold       <= next_tx_hold;
      tx_hold_valid <= next_tx_hold_valid;
      tx_hold_error <= next_tx_hold_error;
      tx_nib        <= next_tx_nib;
      tx_ctl_reg    <= next_tx_ctl_reg;
      tx_clk_reg    <= next_tx_clk_reg;
      speed_active  <= next_speed_active;
      phy_rst_reg   <= phy_reset_release;  // [R8]
      mdio_sync     <= {mdio_sync[0], mdio_in_pin};
      mdio_value    <= mdio_sync[1];
    end
  end

  // ****************************************************************
  // Pin ownership
  // ****************************************************************
  // Pins fall back to general I/O when disabled
  assign tx_data_pin = rgmii_enable ? tx_nib : gpio_out;  // [R1] [R2]
  assign tx_ctl_pin  = rgmii_enable ? tx_ctl_reg : gpio_out_ctl;  // [R1] [R2]
  assign tx_clk_pin  = rgmii_enable ? (clock_delay_on ? tx_clk_delayed : tx_clk_reg)
                                    : gpio_out_clk;  // [R1] [R4]
  // PHY held in reset until released, so its receive clock stays low
  assign phy_reset_n = phy_rst_reg;  // [R8]

  // Open drain: only ever drives low
  assign mdc_out  = 1'b0;  // [R9]
  assign mdc_oe   = mdc_drive_low;  // [R9]
  assign mdio_out = 1'b0;  // [R9]
  assign mdio_oe  = mdio_drive_low;  // [R9]

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_gpio_pass;
    @(posedge clock) disable iff (!arst_n)
      !rgmii_enable |-> (tx_data_pin == gpio_out);
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("gpio not passed"); // [R1]

  property p_own_pins;
    @(posedge clock) disable iff (!arst_n)
      rgmii_enable |-> (tx_data_pin == tx_nib);
  endproperty
  a_own_pins: assert property (p_own_pins) else $error("pins not owned"); // [R2]

  property p_high_nib;
    @(posedge clock) disable iff (!arst_n)
      (rgmii_enable && tick && state == rgb_pkg::RGB_TX_LOW)
        |=> (tx_data_pin == $past(tx_hold[7:4]));
  endproperty
  a_high_nib: assert property (p_high_nib) else $error("high nibble wrong"); // [R3]

  property p_delay;
    @(posedge clock) disable iff (!arst_n)
      (rgmii_enable && clock_delay_on && $stable(clock_delay_on))
        |-> (tx_clk_pin == $past(tx_clk_reg));
  endproperty
  a_delay: assert property (p_delay) else $error("clock delay wrong"); // [R4]

  property p_gig_rate;
    @(posedge clock) disable iff (!arst_n)
      (speed_active == rgb_pkg::SPEED_1000 && rgmii_enable && $past(rgmii_enable)
       && $stable(speed_active)) |-> tick;
  endproperty
  a_gig_rate: assert property (p_gig_rate) else $error("gigabit divider wrong"); // [R5]

  property p_indep;
    @(posedge clock) disable iff (!arst_n)
      $changed(tx_clk_reg) |=> (tx_clk_delayed == $past(tx_clk_reg));
  endproperty
  a_indep: assert property (p_indep) else $error("delay chain broken"); // [R6]

  property p_speed;
    @(posedge clock) disable iff (!arst_n)
      $changed(speed_active) |-> $past(rx_valid_fall);
  endproperty
  a_speed: assert property (p_speed) else $error("speed changed off edge"); // [R7]

  property p_od;
    @(posedge clock) disable iff (!arst_n)
      (mdio_oe |-> !mdio_out) and (mdc_oe |-> !mdc_out);
  endproperty
  a_od: assert property (p_od) else $error("open drain driven high"); // [R9]

  property p_rx_pair;
    @(posedge clock) disable iff (!arst_n)
      rx_strobe |-> (rx_error == (rx_valid ^ $past(u_rx.sync_c[1])));
  endproperty
  a_rx_pair: assert property (p_rx_pair) else $error("rx error pairing wrong"); // [R10]

endmodule

// [rgb_phy_model.sv]
// ******************************
// Link partner: receive side
// ******************************
module rgb_phy_model (
  input  wire logic       phy_reset_n,
  output logic            rx_clk_pin,
  output logic [3:0]      rx_data_pin,
  output logic            rx_ctl_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rx_clk_pin = 1'b0;
    rx_data_pin = 4'h0;
    rx_ctl_pin = 1'b0;
  end

  // Clock stands low outside frames and stays low while held in reset
  task automatic send_byte(input logic [7:0] d, input logic v, input logic e);
    if (phy_reset_n !== 1'b1) begin
      return;
    end
    rx_data_pin = d[3:0];
    rx_ctl_pin = v;
    #31.25;
    rx_clk_pin = 1'b1;
    #31.25;
    rx_data_pin = d[7:4];
    rx_ctl_pin = v ^ e;
    #31.25;
    rx_clk_pin = 1'b0;
    #31.25;
    // Released lines flip to the inverse of the high nibble and control just sent
    rx_data_pin = ~d[7:4];
    rx_ctl_pin = ~(v ^ e);
  endtask
endmodule

// [rgb_bridge_bench.sv]
module rgb_bridge_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clock, arst_n, rgmii_enable, clock_delay_on, phy_reset_release, tx_valid;
  logic       tx_error, tx_ready, rx_valid, rx_error, rx_strobe, gpio_out_clk, gpio_out_ctl;
  logic       tx_clk_pin, tx_ctl_pin, rx_clk_pin, rx_ctl_pin, phy_reset_n, mdc_drive_low;
  logic       mdio_drive_low, mdio_in_pin, mdc_out, mdc_oe, mdio_out, mdio_oe, mdio_value;
  logic       phy_mdio_low;
  logic [1:0] speed_request, speed_active;
  logic [3:0] gpio_out, tx_data_pin, rx_data_pin;
  logic [7:0] transmit_byte_path, receive_byte_path;
  int         num_errors, check_count, cycles;

  localparam logic [1:0] REQ [4] = '{rgb_pkg::SPEED_10, rgb_pkg::SPEED_100, 2'h3,
                                     rgb_pkg::SPEED_1000};
  localparam logic [1:0] EXP [4] = '{rgb_pkg::SPEED_10, rgb_pkg::SPEED_100,
                                     rgb_pkg::SPEED_100, rgb_pkg::SPEED_1000};

  // Open-drain line with pull-up; either side may pull it low
  assign mdio_in_pin = !(mdio_oe && !mdio_out) && !phy_mdio_low;

  rgb_bridge dut (.clock, .arst_n, .rgmii_enable, .clock_delay_on, .speed_request,
    .phy_reset_release, .transmit_byte_path, .tx_valid, .tx_error, .tx_ready,
    .receive_byte_path, .rx_valid, .rx_error, .rx_strobe, .speed_active, .gpio_out,
    .gpio_out_clk, .gpio_out_ctl, .tx_data_pin, .tx_clk_pin, .tx_ctl_pin, .rx_clk_pin,
    .rx_data_pin, .rx_ctl_pin, .phy_reset_n, .mdc_drive_low, .mdio_drive_low,
    .mdio_in_pin, .mdc_out, .mdc_oe, .mdio_out, .mdio_oe, .mdio_value);

  rgb_phy_model phy (.phy_reset_n, .rx_clk_pin, .rx_data_pin, .rx_ctl_pin);

  always #5 clock = ~clock;

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim;
    end
  end

  // ******************************
  // Shared tasks
  // ******************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic send_tx(input logic [7:0] b, input logic v, input logic e);
    int n;
    n = 0;
    @(negedge clock);
    transmit_byte_path = b;
    tx_valid = v;
    tx_error = e;
    while (tx_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check({7'h0, tx_ready}, 8'h01);
    @(negedge clock);
    check({4'h0, tx_data_pin}, {4'h0, b[3:0]});
    check({7'h0, tx_ctl_pin}, {7'h0, v});
    check({7'h0, tx_clk_pin}, {7'h0, ~clock_delay_on});
    @(negedge clock);
    check({4'h0, tx_data_pin}, {4'h0, b[7:4]});
    check({7'h0, tx_ctl_pin}, {7'h0, v ^ e});
    check({7'h0, tx_clk_pin}, {7'h0, clock_delay_on});
    tx_valid = 1'b0;
  endtask

  task automatic wait_strobe;
    int n;
    n = 0;
    @(negedge clock);
    while (rx_strobe !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    check({7'h0, rx_strobe}, 8'h01);
  endtask

  task automatic rx_byte(input logic [7:0] d, input logic v, input logic e,
                         input logic [1:0] sp);
    fork
      phy.send_byte(d, v, e);
      wait_strobe;
    join
    check(receive_byte_path, d);
    check({7'h0, rx_valid}, {7'h0, v});
    check({7'h0, rx_error}, {7'h0, e});
    repeat (2) @(negedge clock);
    check({6'h0, speed_active}, {6'h0, sp});
  endtask

  task automatic mdio_step(input logic drv, input logic low, input logic exp);
    @(negedge clock);
    mdio_drive_low = drv;
    phy_mdio_low = low;
    repeat (2) @(negedge clock);
    check({7'h0, mdio_value}, {7'h0, ~exp});
    @(negedge clock);
    check({7'h0, mdio_value}, {7'h0, exp});
    check({6'h0, mdio_oe, mdio_out}, {6'h0, drv, 1'b0});
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic test_reset;
    check({6'h0, speed_active}, {6'h0, rgb_pkg::SPEED_1000});
    check(receive_byte_path, rgb_pkg::BYTE_RESET);
    phy.send_byte(8'h11, 1'b1, 1'b0);
    check({7'h0, rx_strobe}, 8'h00);
    phy_reset_release = 1'b1;
    @(negedge clock);
    check({7'h0, phy_reset_n}, 8'h01);
  endtask

  task automatic test_gpio;
    @(negedge clock);
    gpio_out = 4'hA;
    gpio_out_clk = 1'b1;
    gpio_out_ctl = 1'b1;
    @(negedge clock);
    check({1'b0, tx_clk_pin, tx_ctl_pin, 1'b0, tx_data_pin}, 8'h6A);
    gpio_out = 4'hF;
    gpio_out_clk = 1'b0;
    gpio_out_ctl = 1'b0;
    @(negedge clock);
    check({1'b0, tx_clk_pin, tx_ctl_pin, 1'b0, tx_data_pin}, 8'h0F);
    rgmii_enable = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  task automatic test_tx;
    send_tx(8'h3C, 1'b1, 1'b0);
    send_tx(8'hA5, 1'b1, 1'b1);
    clock_delay_on = 1'b1;
    repeat (3) @(negedge clock);
    send_tx(8'h96, 1'b1, 1'b0);
    clock_delay_on = 1'b0;
  endtask

  task automatic test_speed;
    logic [1:0] now;
    now = rgb_pkg::SPEED_1000;
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      speed_request = REQ[i];
      rx_byte(8'h5A ^ 8'(i), 1'b1, i[0], now);
      now = EXP[i];
      rx_byte(8'hC3 ^ 8'(i), 1'b0, 1'b0, now);
    end
  endtask

  task automatic test_slow_tx;
    int n;
    n = 0;
    speed_request = rgb_pkg::SPEED_100;
    rx_byte(8'h81, 1'b1, 1'b0, rgb_pkg::SPEED_1000);
    rx_byte(8'h42, 1'b0, 1'b0, rgb_pkg::SPEED_100);
    transmit_byte_path = 8'hE7;
    tx_valid = 1'b1;
    tx_error = 1'b0;
    while (tx_ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check({7'h0, tx_ready}, 8'h01);
    @(negedge clock);
    check({4'h0, tx_data_pin}, 8'h07);
    // Low nibble must stand a whole divider period
    repeat (rgb_pkg::DIV_100 - 1) @(negedge clock);
    check({4'h0, tx_data_pin}, 8'h07);
    @(negedge clock);
    check({4'h0, tx_data_pin}, 8'h0E);
    tx_valid = 1'b0;
    speed_request = rgb_pkg::SPEED_1000;
    rx_byte(8'h24, 1'b1, 1'b0, rgb_pkg::SPEED_100);
    rx_byte(8'h18, 1'b0, 1'b0, rgb_pkg::SPEED_1000);
  endtask

  task automatic test_mdio;
    @(negedge clock);
    mdc_drive_low = 1'b1;
    @(negedge clock);
    check({6'h0, mdc_oe, mdc_out}, 8'h02);
    mdio_step(1'b1, 1'b0, 1'b0);
    mdio_step(1'b0, 1'b0, 1'b1);
    mdio_step(1'b0, 1'b1, 1'b0);
    mdio_step(1'b0, 1'b0, 1'b1);
  endtask

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    {rgmii_enable, clock_delay_on, phy_reset_release, tx_valid, tx_error} = 5'h00;
    {gpio_out_clk, gpio_out_ctl, mdc_drive_low, mdio_drive_low, phy_mdio_low} = 5'h00;
    speed_request = rgb_pkg::SPEED_1000;
    gpio_out = 4'h0;
    transmit_byte_path = 8'h00;
    repeat (3) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    test_reset;
    test_gpio;
    test_tx;
    test_speed;
    test_slow_tx;
    test_mdio;
    end_sim;
  end
endmodule
